// ===== rtl/tcc_defs.vh
// Constants shared by the timer channel control and status logic
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

// ==========================================================
// Channel set
`define TCC_NCH 5
`define TCC_CH_W 3
`define TCC_CH_NO_TOGGLE 2
`define TCC_CH_PHASE 2
`define TCC_CH_PAIR_LO 3
`define TCC_CH_DMA_MAX 3

// ==========================================================
// Register offsets inside one channel window
`define TCC_OFF_PFC 4'h0
`define TCC_OFF_FLAGS 4'h1
`define TCC_OFF_IEN 4'h2
`define TCC_OFF_FIRST16 4'h4
`define TCC_OFF_CNT 4'h4
`define TCC_OFF_CMP_A 4'h6
`define TCC_OFF_CMP_B 4'h8
`define TCC_OFF_BUF_A 4'hA
`define TCC_OFF_BUF_B 4'hC
`define TCC_OFF_LAST16 4'hD

// ==========================================================
// Reset values and fixed bits
`define TCC_PFC_RST 8'h88
`define TCC_PFC_FIXED 8'h88
`define TCC_FLAGS_RST 8'hF8
`define TCC_FLAGS_FIXED 8'hF8
`define TCC_IEN_RST 8'hF8
`define TCC_IEN_FIXED 8'hF8
`define TCC_GR_RST 16'hFFFF
`define TCC_CNT_RST 16'h0000
`define TCC_CNT_MAX 16'hFFFF
`define TCC_BYTE_ZERO 8'h00

// ==========================================================
// Field positions
`define TCC_B_ROLE 6:4
`define TCC_A_ROLE 2:0
`define TCC_EVT_BITS 2:0
`define TCC_WRAP_BIT 2
`define TCC_MFB_BIT 1
`define TCC_MFA_BIT 0
`define TCC_CAP_BIT 2
`define TCC_EDGE_BITS 1:0

// ==========================================================
// Role codes
`define TCC_ROLE_NONE 3'h0
`define TCC_ROLE_LOW 3'h1
`define TCC_ROLE_HIGH 3'h2
`define TCC_ROLE_TOGGLE 3'h3
`define TCC_EDGE_RISE 2'h0
`define TCC_EDGE_FALL 2'h1

`endif

// ===== rtl/tcc_capture_edge.v
// Pin synchroniser and capture edge detector for one capture input
`include "tcc_defs.vh"

module tcc_capture_edge (
  // Clock and initialisation
  input wire clk,
  input wire init,
  // Pin and role selection
  input wire pin,
  input wire [2:0] role,
  // Capture event
  output reg capture
);

  // ==========================================================
  // Two-stage synchroniser, then an edge history stage
  reg sync_1;
  reg sync_2;
  reg last;
  wire rise;
  wire fall;
  reg next_capture;

  assign rise = sync_2 & ~last;
  assign fall = ~sync_2 & last;

  always @* begin
    next_capture = 1'b0;
    if (role[`TCC_CAP_BIT]) begin
      case (role[`TCC_EDGE_BITS])
        `TCC_EDGE_RISE: next_capture = rise;
        `TCC_EDGE_FALL: next_capture = fall;
        default: next_capture = rise | fall;
      endcase
    end
  end

  always @(posedge clk) begin
    if (init) begin
      sync_1 <= 1'b0;
      sync_2 <= 1'b0;
      last <= 1'b0;
      capture <= 1'b0;
    end else begin
      sync_1 <= pin;
      sync_2 <= sync_1;
      last <= sync_2;
      capture <= next_capture;
    end
  end

endmodule

// ===== rtl/tcc_top.v
// Timer channel pin roles, status flags, interrupt enables and CPU access
`include "tcc_defs.vh"

module tcc_top (
  // Clock, reset and standby
  input wire SYS_CLK,
  input wire RST,
  input wire STANDBY,
  // CPU register access
  input wire CPU_REQ,
  input wire CPU_WRITE,
  input wire CPU_WORD,
  input wire [6:0] CPU_ADDR,
  input wire [15:0] CPU_WDATA,
  output reg [15:0] CPU_RDATA,
  output reg CPU_ACK,
  output reg CPU_BUSY,
  // Counter stepping and modes from the counting datapath
  input wire [4:0] CNT_TICK,
  input wire [4:0] CNT_DOWN,
  input wire [4:0] CNT_CLEAR,
  input wire [4:0] PWM_MODE_SEL,
  input wire PHASE_COUNT_SELECT,
  input wire COMBINATION_MODE_BIT,
  input wire RESET_SYNC_PWM_SEL,
  // Channel pins
  input wire [4:0] CHANNEL_PIN_A_IN,
  output reg [4:0] CHANNEL_PIN_A_OUT,
  output reg [4:0] CHANNEL_PIN_A_OE_N,
  input wire [4:0] CHANNEL_PIN_B_IN,
  output reg [4:0] CHANNEL_PIN_B_OUT,
  output reg [4:0] CHANNEL_PIN_B_OE_N,
  // Events to the counting datapath
  output reg [4:0] MATCH_A_PULSE,
  output reg [4:0] MATCH_B_PULSE,
  output reg [4:0] WRAP_PULSE,
  // DMA acknowledge and interrupt requests
  input wire [4:0] DMA_ACK_A,
  output reg [4:0] WRAP_IRQ,
  output reg [4:0] MATCH_IRQ_A,
  output reg [4:0] MATCH_IRQ_B
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_SECOND = 2'b10;

  // ==========================================================
  // Decoding helpers
  function is_wide_reg;
    input [3:0] off;
    begin
      is_wide_reg = (off >= `TCC_OFF_FIRST16) && (off <= `TCC_OFF_LAST16);
    end
  endfunction

  function hit_wide;
    input [3:0] off;
    input [3:0] base;
    begin
      hit_wide = (off[3:1] == base[3:1]);
    end
  endfunction

  // Byte writes keep the other half intact
  function [15:0] merge16;
    input [15:0] old;
    input wide;
    input odd;
    input [15:0] data;
    begin
      if (wide)
        merge16 = data;
      else if (odd)
        merge16 = {old[15:8], data[7:0]};
      else
        merge16 = {data[7:0], old[7:0]};
    end
  endfunction

  wire init = RST | STANDBY;

  // ==========================================================
  // Bus sequencing
  reg [1:0] state;
  reg [1:0] next_state;
  reg [6:0] sv_adr;
  reg sv_we;
  reg [7:0] sv_lo;
  reg acc_en;
  reg acc_we;
  reg acc_wide;
  reg [6:0] acc_adr;
  reg [15:0] acc_wb;
  reg split_first;
  wire [3:0] acc_off = acc_adr[3:0];
  wire acc_odd = acc_adr[0];

  always @* begin
    next_state = state;
    acc_en = 1'b0;
    acc_we = 1'b0;
    acc_wide = 1'b0;
    acc_adr = CPU_ADDR;
    acc_wb = CPU_WDATA;
    split_first = 1'b0;
    case (state)
      ST_IDLE: begin
        if (CPU_REQ) begin
          acc_en = 1'b1;
          acc_we = CPU_WRITE;
          if (CPU_WORD) begin
            acc_adr = {CPU_ADDR[6:1], 1'b0};
            if (is_wide_reg(CPU_ADDR[3:0])) begin
              acc_wide = 1'b1;
            end else begin
              acc_wb = {`TCC_BYTE_ZERO, CPU_WDATA[15:8]};
              split_first = 1'b1;
              next_state = ST_SECOND;
            end
          end else begin
            acc_wb = {`TCC_BYTE_ZERO, CPU_WDATA[7:0]};
          end
        end
      end
      ST_SECOND: begin
        acc_en = 1'b1;
        acc_we = sv_we;
        acc_adr = sv_adr;
        acc_wb = {`TCC_BYTE_ZERO, sv_lo};
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // ==========================================================
  // Channels
  wire [39:0] ch_rd8;
  wire [79:0] ch_rd16;
  wire ovr_pair = COMBINATION_MODE_BIT | RESET_SYNC_PWM_SEL;

  genvar i;
  generate
    for (i = 0; i < `TCC_NCH; i = i + 1) begin : gen_ch
      reg [7:0] pfc;
      reg [7:0] flags;
      reg [7:0] ien;
      reg [2:0] armed;
      reg [15:0] cnt;
      reg [15:0] cmp_a;
      reg [15:0] cmp_b;
      reg [15:0] buf_a;
      reg [15:0] buf_b;
      reg [7:0] rd8;
      reg [15:0] rd16;
      reg [2:0] role_a;
      reg [2:0] role_b;
      reg down_ok;
      reg override;
      reg [7:0] next_flags;
      wire cap_a;
      wire cap_b;
      wire sel = acc_en && (acc_adr[6:4] == i);
      wire wr = sel & acc_we;
      wire rd_flags = sel & ~acc_we & (acc_off == `TCC_OFF_FLAGS);
      wire wr_flags = wr & (acc_off == `TCC_OFF_FLAGS);
      wire step_up = CNT_TICK[i] & ~down_ok;
      wire step_dn = CNT_TICK[i] & down_ok;
      wire wrap = (step_up & (cnt == `TCC_CNT_MAX)) |
                  (step_dn & (cnt == `TCC_CNT_RST));
      // Match fires as the counter leaves the equal value
      wire match_a = ~role_a[`TCC_CAP_BIT] & CNT_TICK[i] & (cnt == cmp_a);
      wire match_b = ~role_b[`TCC_CAP_BIT] & CNT_TICK[i] & (cnt == cmp_b);
      wire [2:0] set_evt = {wrap, match_b | cap_b, match_a | cap_a};
      wire [2:0] clr_evt;
      wire dma_clr;

      if (i <= `TCC_CH_DMA_MAX) begin : g_dma
        assign dma_clr = DMA_ACK_A[i];
      end else begin : g_nodma
        assign dma_clr = 1'b0;
      end

      // Write 0 to a bit that was seen as 1; a written 1 changes nothing
      assign clr_evt = {3{wr_flags}} & ~acc_wb[`TCC_EVT_BITS] & armed |
                       {2'b00, dma_clr};

      always @* begin
        down_ok = 1'b0;
        override = PWM_MODE_SEL[i];
        if (i == `TCC_CH_PHASE)
          down_ok = CNT_DOWN[i] & PHASE_COUNT_SELECT;
        if (i >= `TCC_CH_PAIR_LO) begin
          down_ok = CNT_DOWN[i] & COMBINATION_MODE_BIT;
          override = PWM_MODE_SEL[i] | ovr_pair;
        end
        // Overridden channels act as plain compare with no pin action
        role_a = override ? `TCC_ROLE_NONE : pfc[`TCC_A_ROLE];
        role_b = override ? `TCC_ROLE_NONE : pfc[`TCC_B_ROLE];
        // Set wins over a clear in the same cycle
        next_flags = `TCC_FLAGS_FIXED |
                     {5'b00000, set_evt | (flags[`TCC_EVT_BITS] & ~clr_evt)};
        rd8 = `TCC_BYTE_ZERO;
        case (acc_off)
          `TCC_OFF_PFC: rd8 = pfc | `TCC_PFC_FIXED;
          `TCC_OFF_FLAGS: rd8 = flags | `TCC_FLAGS_FIXED;
          `TCC_OFF_IEN: rd8 = ien | `TCC_IEN_FIXED;
          default: rd8 = `TCC_BYTE_ZERO;
        endcase
        rd16 = {`TCC_BYTE_ZERO, `TCC_BYTE_ZERO};
        if (hit_wide(acc_off, `TCC_OFF_CNT))
          rd16 = cnt;
        else if (hit_wide(acc_off, `TCC_OFF_CMP_A))
          rd16 = cmp_a;
        else if (hit_wide(acc_off, `TCC_OFF_CMP_B))
          rd16 = cmp_b;
        else if (hit_wide(acc_off, `TCC_OFF_BUF_A) && i >= `TCC_CH_PAIR_LO)
          rd16 = buf_a;
        else if (hit_wide(acc_off, `TCC_OFF_BUF_B) && i >= `TCC_CH_PAIR_LO)
          rd16 = buf_b;
      end

      assign ch_rd8[i*8 +: 8] = rd8;
      assign ch_rd16[i*16 +: 16] = rd16;

      tcc_capture_edge u_cap_a (
        .clk(SYS_CLK),
        .init(init),
        .pin(CHANNEL_PIN_A_IN[i]),
        .role(role_a),
        .capture(cap_a)
      );

      tcc_capture_edge u_cap_b (
        .clk(SYS_CLK),
        .init(init),
        .pin(CHANNEL_PIN_B_IN[i]),
        .role(role_b),
        .capture(cap_b)
      );

      always @(posedge SYS_CLK) begin
        if (init) begin
          pfc <= `TCC_PFC_RST;
          flags <= `TCC_FLAGS_RST;
          ien <= `TCC_IEN_RST;
          armed <= 3'b000;
          cnt <= `TCC_CNT_RST;
          cmp_a <= `TCC_GR_RST;
          cmp_b <= `TCC_GR_RST;
          buf_a <= `TCC_GR_RST;
          buf_b <= `TCC_GR_RST;
          CHANNEL_PIN_A_OUT[i] <= 1'b0;
          CHANNEL_PIN_B_OUT[i] <= 1'b0;
          CHANNEL_PIN_A_OE_N[i] <= 1'b1;
          CHANNEL_PIN_B_OE_N[i] <= 1'b1;
          MATCH_A_PULSE[i] <= 1'b0;
          MATCH_B_PULSE[i] <= 1'b0;
          WRAP_PULSE[i] <= 1'b0;
          WRAP_IRQ[i] <= 1'b0;
          MATCH_IRQ_A[i] <= 1'b0;
          MATCH_IRQ_B[i] <= 1'b0;
        end else begin
          if (wr && acc_off == `TCC_OFF_PFC)
            pfc <= acc_wb[7:0] | `TCC_PFC_FIXED;
          if (wr && acc_off == `TCC_OFF_IEN)
            ien <= acc_wb[7:0] | `TCC_IEN_FIXED;
          flags <= next_flags;
          if (rd_flags)
            armed <= flags[`TCC_EVT_BITS];
          else if (wr_flags)
            armed <= 3'b000;
          else
            armed <= armed & next_flags[`TCC_EVT_BITS];
          // CPU write wins over counting
          if (wr && hit_wide(acc_off, `TCC_OFF_CNT))
            cnt <= merge16(cnt, acc_wide, acc_odd, acc_wb);
          else if (CNT_CLEAR[i])
            cnt <= `TCC_CNT_RST;
          else if (step_up)
            cnt <= cnt + 16'h0001;
          else if (step_dn)
            cnt <= cnt - 16'h0001;
          // Capture takes precedence over a CPU write in the same cycle
          if (cap_a)
            cmp_a <= cnt;
          else if (wr && hit_wide(acc_off, `TCC_OFF_CMP_A))
            cmp_a <= merge16(cmp_a, acc_wide, acc_odd, acc_wb);
          if (cap_b)
            cmp_b <= cnt;
          else if (wr && hit_wide(acc_off, `TCC_OFF_CMP_B))
            cmp_b <= merge16(cmp_b, acc_wide, acc_odd, acc_wb);
          if (wr && hit_wide(acc_off, `TCC_OFF_BUF_A) && i >= `TCC_CH_PAIR_LO)
            buf_a <= merge16(buf_a, acc_wide, acc_odd, acc_wb);
          if (wr && hit_wide(acc_off, `TCC_OFF_BUF_B) && i >= `TCC_CH_PAIR_LO)
            buf_b <= merge16(buf_b, acc_wide, acc_odd, acc_wb);
          if (match_a) begin
            case (role_a)
              `TCC_ROLE_LOW: CHANNEL_PIN_A_OUT[i] <= 1'b0;
              `TCC_ROLE_HIGH: CHANNEL_PIN_A_OUT[i] <= 1'b1;
              `TCC_ROLE_TOGGLE: CHANNEL_PIN_A_OUT[i] <=
                (i == `TCC_CH_NO_TOGGLE) | ~CHANNEL_PIN_A_OUT[i];
              default: CHANNEL_PIN_A_OUT[i] <= CHANNEL_PIN_A_OUT[i];
            endcase
          end
          if (match_b) begin
            case (role_b)
              `TCC_ROLE_LOW: CHANNEL_PIN_B_OUT[i] <= 1'b0;
              `TCC_ROLE_HIGH: CHANNEL_PIN_B_OUT[i] <= 1'b1;
              `TCC_ROLE_TOGGLE: CHANNEL_PIN_B_OUT[i] <=
                (i == `TCC_CH_NO_TOGGLE) | ~CHANNEL_PIN_B_OUT[i];
              default: CHANNEL_PIN_B_OUT[i] <= CHANNEL_PIN_B_OUT[i];
            endcase
          end
          // Pin driven only for the three output codes
          CHANNEL_PIN_A_OE_N[i] <= role_a[`TCC_CAP_BIT] | (role_a == `TCC_ROLE_NONE);
          CHANNEL_PIN_B_OE_N[i] <= role_b[`TCC_CAP_BIT] | (role_b == `TCC_ROLE_NONE);
          MATCH_A_PULSE[i] <= match_a | cap_a;
          MATCH_B_PULSE[i] <= match_b | cap_b;
          WRAP_PULSE[i] <= wrap;
          WRAP_IRQ[i] <= next_flags[`TCC_WRAP_BIT] & ien[`TCC_WRAP_BIT];
          MATCH_IRQ_B[i] <= next_flags[`TCC_MFB_BIT] & ien[`TCC_MFB_BIT];
          MATCH_IRQ_A[i] <= next_flags[`TCC_MFA_BIT] & ien[`TCC_MFA_BIT];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Read data selection and bus registers
  reg [7:0] rd_byte;
  reg [15:0] rd_word;

  always @* begin
    rd_word = ch_rd16[15:0];
    rd_byte = `TCC_BYTE_ZERO;
    case (acc_adr[6:4])
      3'h0: rd_word = ch_rd16[15:0];
      3'h1: rd_word = ch_rd16[31:16];
      3'h2: rd_word = ch_rd16[47:32];
      3'h3: rd_word = ch_rd16[63:48];
      3'h4: rd_word = ch_rd16[79:64];
      default: rd_word = {`TCC_BYTE_ZERO, `TCC_BYTE_ZERO};
    endcase
    if (acc_adr[6:4] < `TCC_NCH) begin
      if (is_wide_reg(acc_off))
        rd_byte = acc_odd ? rd_word[7:0] : rd_word[15:8];
      else
        rd_byte = ch_rd8[acc_adr[6:4]*8 +: 8];
    end
  end

  always @(posedge SYS_CLK) begin
    if (init) begin
      state <= ST_IDLE;
      sv_adr <= 7'h00;
      sv_we <= 1'b0;
      sv_lo <= `TCC_BYTE_ZERO;
      CPU_RDATA <= 16'h0000;
      CPU_ACK <= 1'b0;
      CPU_BUSY <= 1'b0;
    end else begin
      state <= next_state;
      CPU_BUSY <= (next_state == ST_SECOND);
      CPU_ACK <= acc_en & ~split_first;
      if (split_first) begin
        sv_adr <= {acc_adr[6:1], 1'b1};
        sv_we <= CPU_WRITE;
        sv_lo <= CPU_WDATA[7:0];
        CPU_RDATA <= {rd_byte, `TCC_BYTE_ZERO};
      end else if (state == ST_SECOND) begin
        CPU_RDATA <= {CPU_RDATA[15:8], rd_byte};
      end else if (acc_en) begin
        CPU_RDATA <= acc_wide ? rd_word : {`TCC_BYTE_ZERO, rd_byte};
      end
    end
  end

endmodule

// ===== tb/tcc_monitor.sv
// Port-level assertions for the timer channel control and status block
module tcc_monitor (
  // Clock, reset and standby
  input logic SYS_CLK,
  input logic RST,
  input logic STANDBY,
  // Register bus
  input logic CPU_REQ,
  input logic CPU_WORD,
  input logic [6:0] CPU_ADDR,
  input logic CPU_ACK,
  input logic CPU_BUSY,
  // Counting, pins, events and requests
  input logic [4:0] CNT_TICK,
  input logic [4:0] CHANNEL_PIN_A_OUT,
  input logic [4:0] CHANNEL_PIN_A_OE_N,
  input logic [4:0] CHANNEL_PIN_B_OUT,
  input logic [4:0] MATCH_A_PULSE,
  input logic [4:0] MATCH_B_PULSE,
  input logic [4:0] WRAP_PULSE,
  input logic [4:0] DMA_ACK_A,
  input logic [4:0] WRAP_IRQ,
  input logic [4:0] MATCH_IRQ_A
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Helpers
  // Offsets 0..3 and 14..15 hold byte-wide registers
  wire byte_reg = CPU_ADDR[3:0] < 4'h4 || CPU_ADDR[3:0] > 4'hD;
  wire take = CPU_REQ && !CPU_BUSY;
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (RST || STANDBY);
  // ==========================================
  // Assertions
  single_ack_a: assert property (take && !(CPU_WORD && byte_reg) |=>
    CPU_ACK && !CPU_BUSY) else $error("single access not acked next cycle");
  split_word_a: assert property (take && CPU_WORD && byte_reg |=>
    CPU_BUSY && !CPU_ACK ##1 CPU_ACK && !CPU_BUSY) else $error("split word timing wrong");
  reset_idle_a: assert property (disable iff (1'b0) RST || STANDBY |=>
    !CPU_ACK && !CPU_BUSY && CHANNEL_PIN_A_OUT == 5'h00 && CHANNEL_PIN_B_OUT == 5'h00
    && CHANNEL_PIN_A_OE_N == 5'h1F && WRAP_IRQ == 5'h00) else $error("outputs not idle");
  pin_a_cause_a: assert property (CHANNEL_PIN_A_OUT != $past(CHANNEL_PIN_A_OUT) |->
    ##[0:1] MATCH_A_PULSE != 5'h00) else $error("pin A moved without match");
  pin_b_cause_a: assert property (CHANNEL_PIN_B_OUT != $past(CHANNEL_PIN_B_OUT) |->
    ##[0:1] MATCH_B_PULSE != 5'h00) else $error("pin B moved without match");
  wrap_cause_a: assert property (
    (WRAP_PULSE & ~($past(CNT_TICK) | $past(CNT_TICK, 2))) == 5'h00) else $error("untimed wrap");
  irq_cause_a: assert property ((WRAP_IRQ & ~$past(WRAP_IRQ)) != 5'h00 |->
    CPU_ACK || CPU_BUSY || $past(CPU_ACK) || $past(CPU_BUSY) || $past(CNT_TICK) != 5'h00)
    else $error("wrap request rose without cause");
  dma_clear_a: assert property (DMA_ACK_A[0] && MATCH_IRQ_A[0] && !CNT_TICK[0] |=>
    !MATCH_IRQ_A[0]) else $error("dma did not clear match A");
  dma_keep_a: assert property (DMA_ACK_A[4] && MATCH_IRQ_A[4] && !take && !CPU_ACK |=>
    MATCH_IRQ_A[4]) else $error("dma cleared channel 4");
  cover property (CPU_BUSY);
  cover property (MATCH_A_PULSE != 5'h00);
  cover property (DMA_ACK_A[0] && MATCH_IRQ_A[0]);
endmodule

// ===== tb/tcc_dma_model.sv
// Behavioural DMA controller answering match A requests
module tcc_dma_model (
  // Clock and reset
  input logic clk,
  input logic rst,
  // Request side
  input logic [4:0] en,
  input logic [4:0] irq,
  output logic [4:0] ack = 5'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  // One-cycle acknowledge, then one cycle low before acknowledging again while the request stands
  always @(negedge clk) begin
    ack <= rst ? 5'h00 : irq & en & ~ack;
  end
endmodule

// ===== tb/tcc_top_bench.sv
// Self-checking bench for the timer channel control and status block
module tcc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Signals
  logic clk = 0, rst = 1, stby = 0, req = 0, wr = 0, wd = 0, phase = 0, comb = 0, rsync = 0;
  logic [6:0] addr = 0;
  logic [15:0] wdata = 0, rd;
  logic [4:0] tick = 0, down = 0, pa_in = 0, pb_in = 0, dma_en = 0;
  wire [15:0] rdata;
  wire ack, busy;
  wire [4:0] pa_out, pa_oe_n, pb_out, pb_oe_n, ma_p, mb_p, wr_p, dack, wirq, iqa, iqb;
  int miscompares = 0, checked = 0;
  always #2 clk = ~clk;
  tcc_top tcc_top_i (.SYS_CLK(clk), .RST(rst), .STANDBY(stby), .CPU_REQ(req), .CPU_WRITE(wr),
    .CPU_WORD(wd), .CPU_ADDR(addr), .CPU_WDATA(wdata), .CPU_RDATA(rdata), .CPU_ACK(ack),
    .CPU_BUSY(busy), .CNT_TICK(tick), .CNT_DOWN(down), .CNT_CLEAR(5'h00), .PWM_MODE_SEL(5'h00),
    .PHASE_COUNT_SELECT(phase), .COMBINATION_MODE_BIT(comb), .RESET_SYNC_PWM_SEL(rsync),
    .CHANNEL_PIN_A_IN(pa_in), .CHANNEL_PIN_A_OUT(pa_out), .CHANNEL_PIN_A_OE_N(pa_oe_n),
    .CHANNEL_PIN_B_IN(pb_in), .CHANNEL_PIN_B_OUT(pb_out), .CHANNEL_PIN_B_OE_N(pb_oe_n),
    .MATCH_A_PULSE(ma_p), .MATCH_B_PULSE(mb_p), .WRAP_PULSE(wr_p), .DMA_ACK_A(dack),
    .WRAP_IRQ(wirq), .MATCH_IRQ_A(iqa), .MATCH_IRQ_B(iqb));
  tcc_dma_model tcc_dma_model_i (.clk(clk), .rst(rst), .en(dma_en), .irq(iqa), .ack(dack));
  // ==========================================
  // Bus and compare tasks
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Request stands one cycle; an idle cycle follows so req is never set twice at one edge
  task automatic cpu(input bit w, input bit word, input logic [6:0] a, input logic [15:0] d);
    int n;
    req = 1;
    wr = w;
    wd = word;
    addr = a;
    wdata = d;
    @(negedge clk);
    req = 0;
    for (n = 0; n < 4 && ack !== 1'b1; n++) @(negedge clk);
    chk("ack", 16'h0001, 16'(ack));
    rd = rdata;
    @(negedge clk);
  endtask
  task automatic rchk(input string n, input bit word, input logic [6:0] a, input logic [15:0] e);
    cpu(0, word, a, 16'h0000);
    chk(n, e, rd);
  endtask
  task automatic ticks(input logic [4:0] m, input int k);
    tick = m;
    repeat (k) @(negedge clk);
    tick = 0;
    @(negedge clk);
  endtask
  task report_and_stop;
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task t_reset;
    rchk("pfc_flags0", 1, 7'h00, 16'h88F8);
    rchk("ien0", 0, 7'h02, 16'h00F8);
    rchk("buf_a0", 1, 7'h0A, 16'h0000);
    rchk("chan5", 0, 7'h50, 16'h0000);
    chk("oe_a", 16'h001F, 16'(pa_oe_n));
  endtask
  task t_pfc;
    cpu(1, 0, 7'h10, 16'h0077);
    rchk("pfc1", 0, 7'h10, 16'h00FF);
    cpu(1, 0, 7'h10, 16'h0013);
    chk("oe_a", 16'h001D, 16'(pa_oe_n));
    chk("oe_b", 16'h001D, 16'(pb_oe_n));
  endtask
  task t_match;
    cpu(1, 0, 7'h00, 16'h0032);
    cpu(1, 1, 7'h06, 16'h0002);
    cpu(1, 1, 7'h08, 16'h0003);
    cpu(1, 0, 7'h02, 16'h0007);
    ticks(5'h01, 2);
    chk("pin_a", 16'h0000, 16'(pa_out));
    ticks(5'h01, 2);
    chk("pin_a", 16'h0001, 16'(pa_out));
    chk("pin_b", 16'h0001, 16'(pb_out));
    chk("irq_ab", 16'h0101, {3'h0, iqa, 3'h0, iqb});
    rchk("flags0", 0, 7'h01, 16'h00FB);
  endtask
  task t_clear;
    cpu(1, 0, 7'h01, 16'h00FF);
    cpu(1, 0, 7'h01, 16'h0000);
    rchk("flags0", 0, 7'h01, 16'h00FB);
    cpu(1, 0, 7'h01, 16'h00FD);
    rchk("flags0", 0, 7'h01, 16'h00F9);
    chk("irq_b", 16'h0000, 16'(iqb));
  endtask
  task t_dma;
    dma_en = 5'h01;
    repeat (3) @(negedge clk);
    dma_en = 5'h00;
    rchk("flags0", 0, 7'h01, 16'h00F8);
    chk("irq_a", 16'h0000, 16'(iqa));
  endtask
  task t_toggle;
    cpu(1, 0, 7'h10, 16'h0003);
    cpu(1, 0, 7'h20, 16'h0003);
    cpu(1, 1, 7'h16, 16'h0000);
    cpu(1, 1, 7'h26, 16'h0000);
    ticks(5'h06, 1);
    chk("pin_a", 16'h0007, 16'(pa_out));
    cpu(1, 1, 7'h14, 16'h0000);
    cpu(1, 1, 7'h24, 16'h0000);
    ticks(5'h06, 1);
    chk("pin_a", 16'h0005, 16'(pa_out));
  endtask
  task t_wrap;
    cpu(1, 1, 7'h34, 16'hFFFF);
    cpu(1, 0, 7'h22, 16'h0004);
    cpu(1, 1, 7'h04, 16'h0005);
    ticks(5'h08, 1);
    rchk("flags3", 0, 7'h31, 16'h00FF);
    // Channel 2 counter still holds 1 from the toggle test; start the down step at zero
    cpu(1, 1, 7'h24, 16'h0000);
    phase = 1;
    comb = 1;
    down = 5'h0D;
    ticks(5'h0D, 1);
    phase = 0;
    comb = 0;
    down = 5'h00;
    rchk("cnt0", 1, 7'h04, 16'h0006);
    rchk("cnt2", 1, 7'h24, 16'hFFFF);
    rchk("cnt3", 1, 7'h34, 16'hFFFF);
    rchk("flags2", 0, 7'h21, 16'h00FD);
    chk("wrap_irq", 16'h0004, 16'(wirq));
  endtask
  task t_override;
    rsync = 1;
    cpu(1, 0, 7'h30, 16'h0002);
    ticks(5'h08, 1);
    chk("pin_a", 16'h0005, 16'(pa_out));
    chk("oe_a", 16'h0018, 16'(pa_oe_n));
    rsync = 0;
  endtask
  task t_capture;
    cpu(1, 0, 7'h40, 16'h0054);
    cpu(1, 1, 7'h44, 16'h0010);
    pa_in = 5'h10;
    pb_in = 5'h10;
    repeat (8) @(negedge clk);
    cpu(1, 1, 7'h44, 16'h0020);
    pa_in = 5'h00;
    pb_in = 5'h00;
    repeat (8) @(negedge clk);
    rchk("cmp_a4", 1, 7'h46, 16'h0010);
    rchk("cmp_b4", 1, 7'h48, 16'h0020);
    rchk("flags4", 0, 7'h41, 16'h00FB);
    cpu(1, 0, 7'h42, 16'h0001);
    dma_en = 5'h10;
    repeat (4) @(negedge clk);
    dma_en = 5'h00;
    rchk("flags4", 0, 7'h41, 16'h00FB);
  endtask
  task t_bytes;
    cpu(1, 0, 7'h08, 16'h00AB);
    rchk("cmp_b0", 1, 7'h08, 16'hAB03);
    rchk("cmp_b0_lo", 0, 7'h09, 16'h0003);
    cpu(1, 1, 7'h10, 16'h0500);
    rchk("pfc_flags1", 1, 7'h10, 16'h8DF9);
  endtask
  task t_standby;
    stby = 1;
    repeat (2) @(negedge clk);
    stby = 0;
    rchk("pfc_flags1", 1, 7'h10, 16'h88F8);
    chk("pin_a", 16'h0000, 16'(pa_out));
  endtask
  // ==========================================
  // Sequence and watchdog
  initial begin
    repeat (3) @(negedge clk);
    rst = 0;
    t_reset;
    t_pfc;
    t_match;
    t_clear;
    t_dma;
    t_toggle;
    t_wrap;
    t_override;
    t_capture;
    t_bytes;
    t_standby;
    report_and_stop;
  end
  // Whole run needs about 150 cycles
  initial begin
    #20000;
    miscompares++;
    report_and_stop;
  end
endmodule
bind tcc_top tcc_monitor tcc_monitor_i (.SYS_CLK(SYS_CLK), .RST(RST), .STANDBY(STANDBY),
  .CPU_REQ(CPU_REQ), .CPU_WORD(CPU_WORD), .CPU_ADDR(CPU_ADDR), .CPU_ACK(CPU_ACK),
  .CPU_BUSY(CPU_BUSY), .CNT_TICK(CNT_TICK), .CHANNEL_PIN_A_OUT(CHANNEL_PIN_A_OUT),
  .CHANNEL_PIN_A_OE_N(CHANNEL_PIN_A_OE_N), .CHANNEL_PIN_B_OUT(CHANNEL_PIN_B_OUT),
  .MATCH_A_PULSE(MATCH_A_PULSE), .MATCH_B_PULSE(MATCH_B_PULSE), .WRAP_PULSE(WRAP_PULSE),
  .DMA_ACK_A(DMA_ACK_A), .WRAP_IRQ(WRAP_IRQ), .MATCH_IRQ_A(MATCH_IRQ_A));
